/* File: logic/hw_strap_mode_config.sv */
// pin-strap decoder for hardware control mode of the speaker amplifier
`timescale 1ns/1ps
module hw_strap_mode_config
  import strap_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        switch_freq_select_pin,
  input  wire logic        parallel_bridge_select_pin,
  input  wire logic        amp_sleep_pin,
  input  wire logic [1:0]  amp_gain_code_pins,
  output amp_cfg_type      cfg,
  output logic             switching_en,
  output logic             outputs_hiz,
  output logic             path_active,
  output logic             i2c_pins_owned
);

  strap_state_type s_reg;
  strap_state_type s_next;

  // ******************************************************************
  // gain decode
  // ******************************************************************
  function automatic logic [7:0] gain_decode(input logic [1:0] code);
    case (code)
      2'h0:    gain_decode = ANALOG_GAIN_00; // [RULE12]
      2'h1:    gain_decode = ANALOG_GAIN_01; // [RULE12]
      2'h2:    gain_decode = ANALOG_GAIN_10; // [RULE12]
      default: gain_decode = ANALOG_GAIN_RESET;
    endcase
  endfunction

  // code 11 gives the bridge and frequency pins to the host port; capture
  // asks this twice, so it lives in one place
  function automatic logic is_software_code(input logic [1:0] code);
    is_software_code = (code == GAIN_CODE_SOFTWARE); // [RULE13]
  endfunction

  // ******************************************************************
  // next state
  // ******************************************************************
  // straps are captured once after reset release; later pin moves are
  // ignored, so a glitchy strap cannot retune the output stage mid-play
  always_comb begin
    s_next = s_reg;
    // sleep pin is asynchronous: three flops, second and third must agree
    s_next.sleep_sync = {s_reg.sleep_sync[1:0], amp_sleep_pin};
    if (s_reg.sleep_sync[1] == s_reg.sleep_sync[2]) begin
      s_next.sleep_stable = s_reg.sleep_sync[2];
    end
    s_next.path_active = 1'b1; // [RULE8]
    case (s_reg.state)
      ST_CAPTURE: begin
        // [RULE15]
        s_next.cfg.software_mode =
          is_software_code(amp_gain_code_pins); // [RULE13]
        if (!is_software_code(amp_gain_code_pins)) begin
          s_next.cfg.pwm_ratio = switch_freq_select_pin ?
            PWM_RATIO_HIGH_PIN : PWM_RATIO_LOW_PIN; // [RULE1] [RULE2]
          s_next.cfg.parallel_bridge_mode =
            parallel_bridge_select_pin; // [RULE3]
          s_next.cfg.bridge_tied_mode =
            !parallel_bridge_select_pin; // [RULE4]
          s_next.cfg.source_right_slot =
            parallel_bridge_select_pin; // [RULE5]
          s_next.cfg.analog_gain =
            gain_decode(amp_gain_code_pins); // [RULE12]
        end
        s_next.cfg.volume_db = VOLUME_DB_FIXED; // [RULE10]
        s_next.cfg.boost_db  = BOOST_DB_FIXED;  // [RULE11]
        s_next.state = ST_RUN;
      end
      ST_RUN: begin
        // run drives the stage every cycle, so every wake lands here
        s_next.switching_en = 1'b1;
        s_next.outputs_hiz  = 1'b0;
        // sleep is a hardware-mode pin only
        if (s_reg.sleep_stable && !s_reg.cfg.software_mode) begin
          s_next.ramp  = SLEEP_RAMP_CYCLES;
          s_next.state = ST_STOPPING; // [RULE7]
        end
      end
      ST_STOPPING: begin
        // graceful wind-down before the stage goes quiet
        if (s_reg.ramp == 4'h0) begin
          s_next.switching_en = 1'b0; // [RULE7]
          s_next.outputs_hiz  = 1'b1; // [RULE7]
          s_next.state        = ST_ASLEEP;
        end else begin
          s_next.ramp = s_reg.ramp - 4'h1;
        end
      end
      ST_ASLEEP: begin
        // a wake is honoured only once fully asleep, so a short pulse on
        // the sleep pin still finishes the wind-down; costs resume latency
        // but never leaves the stage half stopped
        if (!s_reg.sleep_stable) begin
          s_next.state = ST_RUN;
        end
      end
      default: s_next.state = ST_CAPTURE;
    endcase
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  // reset leaves the stage quiet; straps are not looked at here, so the
  // capture cycle after release sees pins that have settled under reset
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{state: ST_CAPTURE, sleep_sync: 3'h0, sleep_stable: 1'b0,
                 ramp: 4'h0, switching_en: 1'b0, outputs_hiz: 1'b1,
                 path_active: 1'b0,
                 cfg: '{pwm_ratio: PWM_RATIO_LOW_PIN,
                        parallel_bridge_mode: 1'b0,
                        bridge_tied_mode: 1'b1,
                        source_right_slot: 1'b0,
                        software_mode: 1'b0,
                        analog_gain: ANALOG_GAIN_RESET,
                        volume_db: VOLUME_DB_FIXED,
                        boost_db: BOOST_DB_FIXED}};
    end else begin
      s_reg <= s_next;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  // outputs straight from the state flops
  assign cfg            = s_reg.cfg;
  assign switching_en   = s_reg.switching_en;
  assign outputs_hiz    = s_reg.outputs_hiz;
  assign path_active    = s_reg.path_active;
  assign i2c_pins_owned = s_reg.cfg.software_mode; // [RULE14]

  // ******************************************************************
  // checks
  // ******************************************************************
  AST_LOW_FREQ: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins != 2'h3
      && !switch_freq_select_pin |=> cfg.pwm_ratio == 5'h10)
    else $error("low strap did not give 16x");
  AST_HIGH_FREQ: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins != 2'h3
      && switch_freq_select_pin |=> cfg.pwm_ratio == 5'h08)
    else $error("high strap did not give 8x");
  AST_PARALLEL_BRIDGE_MODE: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    cfg.parallel_bridge_mode |-> !cfg.bridge_tied_mode)
    else $error("both bridge modes set");
  AST_BTL: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins != 2'h3
      && !parallel_bridge_select_pin |=> cfg.bridge_tied_mode)
    else $error("low bridge strap not stereo");
  AST_RIGHT: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    cfg.parallel_bridge_mode |-> cfg.source_right_slot)
    else $error("parallel mode not on right slot");
  AST_SLEEP: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    s_reg.state == ST_RUN && s_reg.sleep_stable && !cfg.software_mode
      |-> ##17 outputs_hiz && !switching_en)
    else $error("sleep did not reach high impedance");
  AST_PATH: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    s_reg.state == ST_ASLEEP |-> path_active)
    else $error("signal path stopped in sleep");
  AST_VOL: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    cfg.volume_db == 8'h00 && cfg.boost_db == 4'h6) // [RULE11]
    else $error("fixed gain stage moved");
  AST_GAIN: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins == 2'h1
      |=> cfg.analog_gain == 8'hE2)
    else $error("gain code 01 misdecoded");
  AST_SW: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins == 2'h3
      |=> i2c_pins_owned && $stable(cfg.pwm_ratio)) // [RULE14]
    else $error("code 11 did not enter software mode");
  // the remaining gain codes, and the pin-to-mode direction of the bridge
  AST_GAIN_00: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins == 2'h0
      |=> cfg.analog_gain == 8'hC0)
    else $error("gain code 00 misdecoded");
  AST_GAIN_10: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins == 2'h2
      |=> cfg.analog_gain == 8'hFA)
    else $error("gain code 10 misdecoded");
  AST_PARALLEL_BRIDGE_MODE_PIN: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    s_reg.state == ST_CAPTURE && amp_gain_code_pins != 2'h3
      && parallel_bridge_select_pin |=> cfg.parallel_bridge_mode)
    else $error("high bridge strap not parallel");

  // ******************************************************************
  // sleep and wake checks
  // ******************************************************************
  // the stable copy may only follow the pin once two flops agree
  AST_SYNC: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    s_reg.sleep_sync[2] != s_reg.sleep_sync[1]
      |=> $stable(s_reg.sleep_stable))
    else $error("sleep level taken before sync agreed");
  // graceful: the stage keeps switching for the whole wind-down
  AST_WIND: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    s_reg.state == ST_STOPPING |-> switching_en && !outputs_hiz)
    else $error("switching stopped early in wind-down");
  AST_QUIET: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    outputs_hiz |-> !switching_en)
    else $error("stage switching while high impedance");
  AST_SW_AWAKE: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    s_reg.state == ST_RUN && cfg.software_mode |=> s_reg.state == ST_RUN)
    else $error("sleep pin honoured in software mode");
  // resume from sleep takes two edges, since the path never stopped
  AST_WAKE: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    s_reg.state == ST_ASLEEP && !s_reg.sleep_stable
      |-> ##2 switching_en && !outputs_hiz)
    else $error("slow resume from sleep");

  // ******************************************************************
  // coverage of the main scenarios
  // ******************************************************************
  COV_SLEEP: cover property (@(posedge clk) s_reg.state == ST_ASLEEP);
  COV_WAKE: cover property (@(posedge clk)
    s_reg.state == ST_ASLEEP ##1 s_reg.state == ST_RUN);
  COV_SW: cover property (@(posedge clk) i2c_pins_owned);
  COV_PB: cover property (@(posedge clk) cfg.parallel_bridge_mode);
  COV_SW_SLEEP: cover property (@(posedge clk)
    i2c_pins_owned && s_reg.sleep_stable);

endmodule

/* File: logic/strap_cfg_pkg.sv */
// constants and types for the pin-strap configuration decoder
//
// Contract
// RULE1: hardware mode, frequency pin low selects switching at sixteen times sample rate.
// RULE2: hardware mode, frequency pin high selects switching at eight times sample rate.
// RULE3: hardware mode, bridge select pin high selects parallel bridge output.
// RULE4: hardware mode, bridge select pin low selects stereo bridge-tied output.
// RULE5: parallel bridge mode takes its source from the right channel slot.
// RULE6: sender may invert word select to move the wanted channel to right.
// RULE7: sleep pin high stops switching gracefully and holds outputs in high impedance; the code ignores the pin in software mode.
// RULE8: during sleep the signal path blocks keep running for fast resume.
// RULE9: controller should assert sleep before stopping audio or removing supplies.
// RULE10: hardware mode keeps digital volume fixed at zero decibels.
// RULE11: digital boost stays at six decibels for every hardware gain code.
// RULE12: gain codes 00, 01, 10 give 19.2, 22.6, 25 dBV analog gain.
// RULE13: gain code 11 leaves hardware control and enters software control mode.
// RULE14: software mode hands bridge pin to I2C clock, frequency pin to data.
// RULE15: strap pins stay stable; sampled at reset release, then static.
package strap_cfg_pkg;

  // ******************************************************************
  // encodings and fixed values
  // ******************************************************************
  localparam logic [4:0] PWM_RATIO_LOW_PIN  = 5'h10; // 16 x fs
  localparam logic [4:0] PWM_RATIO_HIGH_PIN = 5'h08; // 8 x fs
  localparam logic [1:0] GAIN_CODE_SOFTWARE = 2'h3;
  // analog gain in tenths of dBV
  localparam logic [7:0] ANALOG_GAIN_00 = 8'hC0; // 19.2
  localparam logic [7:0] ANALOG_GAIN_01 = 8'hE2; // 22.6
  localparam logic [7:0] ANALOG_GAIN_10 = 8'hFA; // 25.0
  localparam logic [7:0] ANALOG_GAIN_RESET = 8'h00;
  localparam logic [7:0] VOLUME_DB_FIXED = 8'h00; // 0 dB
  localparam logic [3:0] BOOST_DB_FIXED  = 4'h6;  // +6 dB
  // ramp length of the graceful stop of switching, in cycles
  localparam logic [3:0] SLEEP_RAMP_CYCLES = 4'hF;

  typedef enum logic [3:0] {
    ST_CAPTURE  = 4'h1,
    ST_RUN      = 4'h2,
    ST_STOPPING = 4'h4,
    ST_ASLEEP   = 4'h8
  } amp_state_type;

  typedef struct packed {
    logic [4:0] pwm_ratio;
    logic       parallel_bridge_mode;
    logic       bridge_tied_mode;
    logic       source_right_slot;
    logic       software_mode;
    logic [7:0] analog_gain;
    logic [7:0] volume_db;
    logic [3:0] boost_db;
  } amp_cfg_type;

  typedef struct packed {
    amp_state_type state;
    logic [2:0]    sleep_sync;
    logic          sleep_stable;
    logic [3:0]    ramp;
    logic          switching_en;
    logic          outputs_hiz;
    logic          path_active;
    amp_cfg_type   cfg;
  } strap_state_type;

endpackage

/* File: verification/hw_strap_mode_config_tb_top.sv */
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  miscompares++; $display("unexpected %s exp %h seen %h", what, exp, got); end end
module hw_strap_mode_config_tb_top
  import strap_cfg_pkg::*;
;
  logic        clk, reset, misbehave, sleep_req, fq, pb, slp, i2c;
  logic        sw_en, hiz, path, want_left, ws_inv;
  logic [3:0]  strap_req, s;
  logic [1:0]  gain;
  logic [31:0] seed;
  amp_cfg_type cfg, e;
  int          miscompares, n_compared, k;

  // ************************************************************
  // clock, partner and design
  // ************************************************************
  initial begin
    clk = 1'b1;
    forever #2.5 clk = ~clk;
  end
  strap_board_model board_u (.reset(reset), .misbehave(misbehave),
    .strap_req(strap_req), .sleep_req(sleep_req),
    .switch_freq_select_pin(fq), .parallel_bridge_select_pin(pb),
    .amp_gain_code_pins(gain), .amp_sleep_pin(slp),
    .want_left(want_left), .word_select_inverted(ws_inv));
  hw_strap_mode_config dut_u (.clk(clk), .reset(reset),
    .switch_freq_select_pin(fq), .parallel_bridge_select_pin(pb),
    .amp_sleep_pin(slp), .amp_gain_code_pins(gain), .cfg(cfg),
    .switching_en(sw_en), .outputs_hiz(hiz), .path_active(path),
    .i2c_pins_owned(i2c));

  // ************************************************************
  // expectations and helpers
  // ************************************************************
  function automatic amp_cfg_type exp_cfg(input logic [3:0] v);
    amp_cfg_type c;
    c = '{PWM_RATIO_LOW_PIN, 1'b0, 1'b1, 1'b0, 1'b1, ANALOG_GAIN_RESET,
          VOLUME_DB_FIXED, BOOST_DB_FIXED};
    // software mode keeps reset values of pwm and bridge
    if (v[1:0] != GAIN_CODE_SOFTWARE) begin
      c.software_mode = 1'b0;
      c.pwm_ratio = v[3] ? PWM_RATIO_HIGH_PIN : PWM_RATIO_LOW_PIN;
      {c.parallel_bridge_mode, c.bridge_tied_mode} = {v[2], !v[2]};
      c.source_right_slot = v[2];
      c.analog_gain = (v[1:0] == 2'h0) ? ANALOG_GAIN_00 :
                      (v[1:0] == 2'h1) ? ANALOG_GAIN_01 : ANALOG_GAIN_10;
    end
    return c;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check_cfg();
    e = exp_cfg(s);
    `CHK("pwm_ratio", e.pwm_ratio, cfg.pwm_ratio)
    `CHK("parallel", e.parallel_bridge_mode, cfg.parallel_bridge_mode)
    `CHK("bridge_tied", e.bridge_tied_mode, cfg.bridge_tied_mode)
    `CHK("right_slot", e.source_right_slot, cfg.source_right_slot)
    `CHK("analog_gain", e.analog_gain, cfg.analog_gain)
    `CHK("software", e.software_mode, cfg.software_mode)
    `CHK("volume", VOLUME_DB_FIXED, cfg.volume_db)
    `CHK("boost", BOOST_DB_FIXED, cfg.boost_db)
    `CHK("i2c_pins", e.software_mode, i2c)
    // right slot plus inverted word select must play the wanted channel
    if (e.parallel_bridge_mode) begin
      `CHK("played", want_left, cfg.source_right_slot ~^ ws_inv)
    end
  endtask
  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence: all 16 strap sets, then random ones
  // ************************************************************
  initial begin
    {reset, misbehave, sleep_req, strap_req} = {3'b100, 4'h0};
    seed = 32'h0E3A6D81;
    for (int t = 0; t < 24; t++) begin
      seed = lfsr(seed);
      s = (t < 16) ? 4'(t) : seed[3:0];
      strap_req = s;
      want_left = seed[4];
      reset = 1'b1;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      check_cfg();
      `CHK("running", 3'b101, {sw_en, hiz, path})
      // late strap movement must be ignored
      misbehave = 1'b1;
      strap_req = ~s;
      @(negedge clk);
      misbehave = 1'b0;
      repeat (3) @(negedge clk);
      check_cfg();
      // sleep: wind-down bounded; software mode ignores it
      sleep_req = 1'b1;
      for (k = 0; k < 40 && hiz !== 1'b1; k++) @(negedge clk);
      `CHK("hiz", !e.software_mode, hiz)
      `CHK("sw_en", e.software_mode, sw_en)
      `CHK("path_asleep", 1'b1, path)
      sleep_req = 1'b0;
      for (k = 0; k < 12 && sw_en !== 1'b1; k++) @(negedge clk);
      `CHK("wake", 2'b10, {sw_en, hiz})
      $display("test %0d straps %h done", t, s);
    end
    complete_run();
  end
  // watchdog: about 1200 cycles expected
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    complete_run();
  end
endmodule

/* File: verification/strap_board_model.sv */
// board-side model: strap levels and host-driven sleep line
`timescale 1ns/1ps
module strap_board_model (
  input  wire logic       reset,
  input  wire logic       misbehave,
  input  wire logic [3:0] strap_req,
  input  wire logic       sleep_req,
  input  wire logic       want_left,
  output logic            switch_freq_select_pin,
  output logic            parallel_bridge_select_pin,
  output logic [1:0]      amp_gain_code_pins,
  output logic            amp_sleep_pin,
  output logic            word_select_inverted
);
  logic [3:0] held;
  // straps move only under reset; misbehave is a commanded rule breach
  always @* begin
    if (reset || misbehave) begin
      held = strap_req;
    end
  end
  assign {switch_freq_select_pin, parallel_bridge_select_pin} = held[3:2];
  assign amp_gain_code_pins = held[1:0];
  // host raises sleep before stopping audio or supplies
  assign amp_sleep_pin = sleep_req;
  // a host that wants the left channel in a parallel stage inverts word
  // select, so that channel lands in the right slot
  assign word_select_inverted = want_left;
endmodule
